// ### msq_host_model.sv
/*
 * Host side of the serial port: frames and chip-select wake pulses.
 * Assumes a 160 ns serial clock that stands still between frames.
 */
`timescale 1ns/1ps
`default_nettype none
module msq_host_model (
    // Serial pins
    output logic sclk,
    output logic csN,
    output logic mosi,
    input wire logic miso,
    input wire logic misoOeN
);
    initial begin
        sclk = 1'b0;
        csN = 1'b1;
        mosi = 1'b0;
    end
    // Frame of nbits, MSB first; lengths other than 8 test refusal
    task automatic xfer(input logic [7:0] cmd, input int nbits, output logic [7:0] rx);
        rx = 8'h0;
        csN = 1'b0;
        #80;
        for (int i = 0; i < nbits; i++) begin
            mosi = cmd[7 - i];
            #80;
            rx = {rx[6:0], misoOeN ? 1'bx : miso};
            sclk = 1'b1;
            #80;
            sclk = 1'b0;
        end
        #80;
        csN = 1'b1;
        mosi = ~mosi;
        #4000;
    endtask
    // Bare chip-select pulse; the caller keeps the wait before commands
    task automatic csWake();
        csN = 1'b0;
        #1000;
        csN = 1'b1;
    endtask
endmodule
`default_nettype wire

// ### msq_mode_checker.sv
/*
 * Port checker for the mode sequencer, bound to msq_mode_sequencer.
 * Assumes the bench never enables PWM control of the switches.
 */
`timescale 1ns/1ps
`default_nettype none
module msq_mode_checker #(
    parameter int unsigned CYC_NRTOUT = 2000,
    parameter int unsigned CYC_TXDDOM = 500
) (
    // Clock, reset and pins
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic csN,
    input wire logic txdIn,
    // Outputs watched
    input wire logic linDriveDom,
    input wire logic highSideSwitch,
    input wire logic lowSideSwitch,
    input wire logic rstPinOeN,
    input wire logic irqN,
    input wire msq_pkg::msq_mode_t mode
);
    logic [1:0] csS_q;
    logic [15:0] csAge_q;
    logic [31:0] nrCnt_q;
    logic [31:0] txdRun_q;
    logic stopCs_q;
    wire csRise = csS_q[0] & ~csS_q[1];
    // Own sync of chip select; its rising edge comes one cycle before the design's
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            csS_q <= 2'h3;
            csAge_q <= 16'hffff;
            nrCnt_q <= 32'h0;
            txdRun_q <= 32'h0;
            stopCs_q <= 1'b0;
        end else begin
            csS_q <= {csS_q[0], csN};
            csAge_q <= csRise ? 16'h0 : csAge_q + {15'h0, csAge_q != 16'hffff};
            nrCnt_q <= (mode == msq_pkg::MD_NREQ) ? nrCnt_q + 32'h1 : 32'h0;
            txdRun_q <= txdIn ? 32'h0 : txdRun_q + 32'h1;
            stopCs_q <= (mode == msq_pkg::MD_STOP) && (stopCs_q || csRise);
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    chk_rst_pull: assert property ((mode == msq_pkg::MD_RESET) [*2] |-> !rstPinOeN)
        else $error("reset pin not pulled in reset mode");
    chk_nreq_free: assert property ((mode == msq_pkg::MD_NREQ) [*2] |-> rstPinOeN)
        else $error("reset pin held in normal request");
    chk_reset_exit: assert property ($past(mode) == msq_pkg::MD_RESET
        && mode != msq_pkg::MD_RESET |-> mode == msq_pkg::MD_NREQ)
        else $error("reset mode left to a wrong mode");
    chk_nreq_limit: assert property (nrCnt_q <= CYC_NRTOUT + 8)
        else $error("normal request outlived its timeout");
    chk_stop_entry: assert property ($rose(mode == msq_pkg::MD_STOP) |-> csAge_q <= 500)
        else $error("stop entered late");
    chk_wdog_norm: assert property ($past(mode) == msq_pkg::MD_NREQ
        && mode == msq_pkg::MD_NORM |-> csAge_q <= 1000)
        else $error("normal entered without a timely trigger");
    chk_switch_delay: assert property (mode == $past(mode)
        && !$stable({highSideSwitch, lowSideSwitch}) |-> csAge_q <= 1000)
        else $error("switch moved without a recent command");
    chk_cs_wake: assert property ($rose(mode == msq_pkg::MD_NREQ) && $past(stopCs_q)
        |-> csAge_q >= 880 && csAge_q <= 7990)
        else $error("chip select wake outside its window");
    chk_irq_release: assert property ($rose(irqN) |-> csAge_q <= 8)
        else $error("interrupt released without a read");
    chk_txd_cut: assert property (txdRun_q > CYC_TXDDOM + 8 |-> !linDriveDom)
        else $error("dominant drive not cut off");
    cover property ($rose(mode == msq_pkg::MD_STOP));
    cover property ($fell(irqN));
    cover property ($past(mode) == msq_pkg::MD_NREQ && mode == msq_pkg::MD_RESET);
endmodule
bind msq_mode_sequencer msq_mode_checker #(
    .CYC_NRTOUT(CYC_NRTOUT),
    .CYC_TXDDOM(CYC_TXDDOM)
) msq_mode_checker_i (
    .clk_sys(clk_sys),
    .rst(rst),
    .csN(csN),
    .txdIn(txdIn),
    .linDriveDom(linDriveDom),
    .highSideSwitch(highSideSwitch),
    .lowSideSwitch(lowSideSwitch),
    .rstPinOeN(rstPinOeN),
    .irqN(irqN),
    .mode(mode)
);
`default_nettype wire

// ### msq_mode_sequencer.sv
/*
 * Operating-mode sequencer: modes, wake filters, switch control, interrupt.
 * Assumes a 100 MHz clk_sys and a host that keeps the serial timing and the
 * wait after a chip-select wake; all pins arrive asynchronously.
 */
// What this block does
// - Stop command takes effect within 5.0 us of chip select rising.
// - Normal Request lasts at most the 150 ms timeout from entry or the last external reset.
// - Switches follow a switch command within 10 us of chip select rising.
// - Watchdog trigger in Normal Request moves to Normal within 10 us.
// - Chip-select wake from Stop reaches Normal Request in 9.0 to 80 us.
// - Bus wake needs a dominant level of about 70 us in Sleep or Stop.
// - Bus wake in Stop pulls the interrupt low about 13 us later.
// - Transmit input dominant for 1.0 s is flagged as permanent dominant.
// - Frames are exactly eight bits, latched on chip select rising.
// - Chip select rising in Stop is a wake-up.
// - Interrupt is active low and released only by a status read.
// - Releasing the reset line enters Normal Request.
`timescale 1ns/1ps
`default_nettype none
module msq_mode_sequencer #(
    parameter int unsigned NWAKE = 4,
    parameter int unsigned CYC_NRTOUT = msq_pkg::CYC_NRTOUT,
    parameter int unsigned CYC_RST = msq_pkg::CYC_RST,
    parameter int unsigned CYC_PROPWL = msq_pkg::CYC_PROPWL,
    parameter int unsigned CYC_TXDDOM = msq_pkg::CYC_TXDDOM
) (
    // System clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Serial port
    input wire logic sclk,
    input wire logic csN,
    input wire logic mosi,
    output logic miso,
    output logic misoOeN,
    // Bus transceiver
    input wire logic linDominant,
    input wire logic txdIn,
    output logic linDriveDom,
    // Wake inputs
    input wire logic [NWAKE-1:0] wakeIn,
    // Switch control
    input wire logic pwmControlInput,
    output logic highSideSwitch,
    output logic lowSideSwitch,
    // Reset pin, open drain
    input wire logic rstPinIn,
    output logic rstPinOut,
    output logic rstPinOeN,
    // Interrupt, regulator and mode
    output logic irqN,
    output logic vddOn,
    output msq_pkg::msq_mode_t mode
);
    typedef struct packed {
        logic [1:0] csS;
        logic csPrev;
        logic [1:0] busS;
        logic [1:0] txdS;
        logic [1:0] pwmS;
        logic [1:0] rstS;
        logic [NWAKE-1:0] lx1;
        logic [NWAKE-1:0] lx2;
        logic [NWAKE-1:0] lxPrev;
        logic [NWAKE-1:0] lxRef;
        msq_pkg::msq_mode_t mode;
        logic [31:0] tmr;
        logic [31:0] lxCnt;
        logic [31:0] busCnt;
        logic [31:0] txdCnt;
        logic [31:0] irqDly;
        logic csWake;
        logic busPend;
        logic fTxd;
        logic fBus;
        logic fLx;
        logic fCs;
        logic hsOn;
        logic lsOn;
        logic pwmEn;
        logic [7:0] snap;
        logic hsOut;
        logic lsOut;
        logic linDom;
        logic irqN;
        logic rstDrv;
        logic vdd;
    } msq_state_t;

    msq_state_t q;
    msq_state_t d;
    msq_pkg::msq_frame_t frame;
    logic csRise;
    logic frameOk;
    logic [2:0] op;
    logic lowPwr;
    logic active;
    logic busWake;
    logic lxWake;
    logic extRst;

    msq_spi_link u_link (
        .sclk(sclk),
        .rst(rst),
        .csN(csN),
        .mosi(mosi),
        .miso(miso),
        .misoOeN(misoOeN),
        .snap(q.snap),
        .frame(frame)
    );

    always_comb begin
        d = q;
        // Synchronisers: first stage feeds only the second
        d.csS = {q.csS[0], csN};
        d.csPrev = q.csS[1];
        d.busS = {q.busS[0], linDominant};
        d.txdS = {q.txdS[0], txdIn};
        d.pwmS = {q.pwmS[0], pwmControlInput};
        d.rstS = {q.rstS[0], rstPinIn};
        d.lx1 = wakeIn;
        d.lx2 = q.lx1;
        d.lxPrev = q.lx2;
        d.tmr = q.tmr + 32'h1;

        csRise = q.csS[1] && !q.csPrev;
        // Shift data is stable here: the link clock is idle once chip select rose
        frameOk = csRise && (frame.cnt == 4'(msq_pkg::FRAME_BITS));
        op = frame.data[msq_pkg::OP_MSB:msq_pkg::OP_LSB];
        lowPwr = (q.mode == msq_pkg::MD_STOP) || (q.mode == msq_pkg::MD_SLEEP);
        active = (q.mode == msq_pkg::MD_NREQ) || (q.mode == msq_pkg::MD_NORM);
        extRst = active && !q.rstS[1] && (q.tmr >= msq_pkg::CYC_RST_GUARD);

        // Bus wake deglitch, only in the low-power modes
        busWake = 1'b0;
        if (lowPwr && q.busS[1] && !q.busPend) begin
            d.busCnt = q.busCnt + 32'h1;
            if (q.busCnt == CYC_PROPWL - 1) begin
                busWake = 1'b1;
                d.busCnt = 32'h0;
            end
        end else begin
            d.busCnt = 32'h0;
        end

        // Wake input filter: a changed level must stay put for the whole filter time
        lxWake = 1'b0;
        if (!lowPwr) begin
            d.lxRef = q.lx2;
            d.lxCnt = 32'h0;
        end else if (q.lx2 != q.lxPrev || q.lx2 == q.lxRef) begin
            d.lxCnt = 32'h0;
        end else begin
            d.lxCnt = q.lxCnt + 32'h1;
            if (q.lxCnt == msq_pkg::CYC_WUF - 1) begin
                lxWake = 1'b1;
                d.lxRef = q.lx2;
            end
        end

        // Permanent dominant detection; the driver is cut while it lasts
        if (!q.txdS[1]) begin
            if (q.txdCnt != CYC_TXDDOM) begin
                d.txdCnt = q.txdCnt + 32'h1;
            end
        end else begin
            d.txdCnt = 32'h0;
        end

        // Status read acknowledges the flags; sets below come later and win
        if (frameOk && op == msq_pkg::OP_READ && active) begin
            d.fTxd = 1'b0;
            d.fBus = 1'b0;
            d.fLx = 1'b0;
            d.fCs = 1'b0;
        end
        if (q.txdCnt == CYC_TXDDOM - 1) begin
            d.fTxd = 1'b1;
        end

        // Switch command is honoured only where the switches may run
        if (frameOk && op == msq_pkg::OP_SWITCH && active) begin
            d.hsOn = frame.data[msq_pkg::SW_HS_BIT];
            d.lsOn = frame.data[msq_pkg::SW_LS_BIT];
            d.pwmEn = frame.data[msq_pkg::SW_PWM_BIT];
        end

        case (q.mode)
            msq_pkg::MD_RESET: begin
                d.rstDrv = 1'b1;
                d.vdd = 1'b1;
                if (q.tmr >= CYC_RST - 1) begin
                    d.mode = msq_pkg::MD_NREQ;
                    d.rstDrv = 1'b0;
                    d.tmr = 32'h0;
                end
            end
            msq_pkg::MD_NREQ: begin
                if (extRst) begin
                    d.tmr = 32'h0;
                end else if (frameOk && op == msq_pkg::OP_WDTRIG) begin
                    d.mode = msq_pkg::MD_NORM;
                    d.tmr = 32'h0;
                end else if (q.tmr >= CYC_NRTOUT - 1) begin
                    d.mode = msq_pkg::MD_RESET;
                    d.rstDrv = 1'b1;
                    d.tmr = 32'h0;
                end
            end
            msq_pkg::MD_NORM: begin
                if (extRst) begin
                    d.mode = msq_pkg::MD_NREQ;
                    d.tmr = 32'h0;
                end else if (frameOk && op == msq_pkg::OP_STOP) begin
                    d.mode = msq_pkg::MD_STOP;
                    d.tmr = 32'h0;
                end else if (frameOk && op == msq_pkg::OP_SLEEP) begin
                    d.mode = msq_pkg::MD_SLEEP;
                    d.vdd = 1'b0;
                    d.tmr = 32'h0;
                end
            end
            msq_pkg::MD_STOP: begin
                // Frames during Stop are ignored; only the chip select edge matters
                if (q.csWake) begin
                    if (q.tmr >= msq_pkg::CYC_WUCS - 1) begin
                        d.mode = msq_pkg::MD_NREQ;
                        d.csWake = 1'b0;
                        d.tmr = 32'h0;
                    end
                end else if (q.busPend) begin
                    d.irqDly = q.irqDly + 32'h1;
                    if (q.irqDly >= msq_pkg::CYC_WAKE_STOP - 1) begin
                        d.fBus = 1'b1;
                        d.busPend = 1'b0;
                        d.mode = msq_pkg::MD_NREQ;
                        d.tmr = 32'h0;
                    end
                end else if (csRise) begin
                    d.csWake = 1'b1;
                    d.fCs = 1'b1;
                    d.tmr = 32'h0;
                end else if (busWake) begin
                    d.busPend = 1'b1;
                    d.irqDly = 32'h0;
                end else if (lxWake) begin
                    d.fLx = 1'b1;
                    d.mode = msq_pkg::MD_NREQ;
                    d.tmr = 32'h0;
                end
            end
            msq_pkg::MD_SLEEP: begin
                // Regulator is off, so any wake restarts through a reset
                if (busWake || lxWake) begin
                    d.fBus = q.fBus | busWake;
                    d.fLx = q.fLx | lxWake;
                    d.mode = msq_pkg::MD_RESET;
                    d.rstDrv = 1'b1;
                    d.vdd = 1'b1;
                    d.tmr = 32'h0;
                end
            end
            default: begin
                d.mode = msq_pkg::MD_RESET;
                d.tmr = 32'h0;
            end
        endcase

        if (d.mode != msq_pkg::MD_NORM && d.mode != msq_pkg::MD_NREQ) begin
            d.hsOn = 1'b0;
            d.lsOn = 1'b0;
            d.pwmEn = 1'b0;
        end
        d.hsOut = d.hsOn && (!d.pwmEn || q.pwmS[1]);
        d.lsOut = d.lsOn && (!d.pwmEn || q.pwmS[1]);
        d.linDom = active && !q.txdS[1] && (q.txdCnt < CYC_TXDDOM);
        d.irqN = !(d.fTxd || d.fBus || d.fLx || d.fCs);

        // Snapshot frozen while a frame runs so the link sees stable bits
        if (q.csS[1]) begin
            d.snap = 8'h00;
            d.snap[msq_pkg::ST_TXDOM] = q.fTxd;
            d.snap[msq_pkg::ST_WBUS] = q.fBus;
            d.snap[msq_pkg::ST_WLX] = q.fLx;
            d.snap[msq_pkg::ST_WCS] = q.fCs;
            d.snap[msq_pkg::ST_HS] = q.hsOn;
            d.snap[msq_pkg::ST_LS] = q.lsOn;
            d.snap[msq_pkg::ST_PWM] = q.pwmEn;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.csS <= 2'h3;
            q.csPrev <= 1'b1;
            q.txdS <= 2'h3;
            q.rstS <= 2'h3;
            q.mode <= msq_pkg::MD_RESET;
            q.irqN <= 1'b1;
            q.rstDrv <= 1'b1;
            q.vdd <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign highSideSwitch = q.hsOut;
    assign lowSideSwitch = q.lsOut;
    assign linDriveDom = q.linDom;
    assign irqN = q.irqN;
    assign vddOn = q.vdd;
    assign mode = q.mode;
    assign rstPinOut = 1'b0;
    assign rstPinOeN = !q.rstDrv;
endmodule
`default_nettype wire

// ### msq_mode_sequencer_test.sv
/*
 * Self-checking bench of the mode sequencer with a host model.
 * Assumes shortened timeouts; the reset pin has a pull-up.
 */
`timescale 1ns/1ps
`default_nettype none
module msq_mode_sequencer_test;
    localparam int unsigned NRT = 20000;
    logic clk_sys, rst, sclk, csN, mosi, miso, misoOeN, linDominant, txdIn;
    logic linDriveDom, pwmControlInput, highSideSwitch, lowSideSwitch;
    logic rstPinIn, rstPinOut, rstPinOeN, irqN, vddOn;
    logic [3:0] wakeIn;
    logic [1:0] sw;
    logic [7:0] rx;
    logic [31:0] seed = 32'hdeff7ead;
    msq_pkg::msq_mode_t mode;
    int n_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    int n;
    assign rstPinIn = rstPinOeN ? 1'b1 : rstPinOut;
    msq_mode_sequencer #(.CYC_NRTOUT(NRT), .CYC_RST(100), .CYC_PROPWL(200),
        .CYC_TXDDOM(500)) msq_mode_sequencer_i (.clk_sys(clk_sys), .rst(rst),
        .sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso), .misoOeN(misoOeN),
        .linDominant(linDominant), .txdIn(txdIn), .linDriveDom(linDriveDom),
        .wakeIn(wakeIn), .pwmControlInput(pwmControlInput),
        .highSideSwitch(highSideSwitch), .lowSideSwitch(lowSideSwitch),
        .rstPinIn(rstPinIn), .rstPinOut(rstPinOut), .rstPinOeN(rstPinOeN),
        .irqN(irqN), .vddOn(vddOn), .mode(mode));
    msq_host_model msq_host_model_i (.sclk(sclk), .csN(csN), .mosi(mosi),
        .miso(miso), .misoOeN(misoOeN));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] opByte(logic [2:0] op, logic [4:0] arg);
        return {op, arg};
    endfunction
    task automatic check(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic cycles(input int k);
        repeat (k) @(negedge clk_sys);
    endtask
    task automatic wait_mode(input msq_pkg::msq_mode_t m, input int lim, output int k);
        k = 0;
        while (mode !== m && k < lim) begin
            @(negedge clk_sys);
            k++;
        end
    endtask
    // PWM level only moves once per frame, far below its ceiling
    task automatic cmd(input logic [7:0] c);
        pwmControlInput = rnd() & 32'h1;
        msq_host_model_i.xfer(c, 8, rx);
    endtask
    task automatic goStop();
        cmd(opByte(msq_pkg::OP_WDTRIG, 5'h0));
        check(mode === msq_pkg::MD_NORM, "trigger to normal");
        cmd(opByte(msq_pkg::OP_STOP, 5'h0));
        cycles(100);
        check(mode === msq_pkg::MD_STOP, "stop entry");
    endtask
    task automatic report_and_stop();
        $display("Checks %0d, errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        // Whole run needs about 51000 cycles; the ceiling leaves margin for slow paths
        if (cyc == 80000) begin
            n_errors++;
            report_and_stop();
        end
    end
    initial begin
        rst = 1'b1;
        linDominant = 1'b0;
        txdIn = 1'b1;
        wakeIn = 4'h0;
        pwmControlInput = 1'b0;
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        cycles(5);
        check(mode === msq_pkg::MD_RESET && rstPinOeN === 1'b0, "reset pulse");
        wait_mode(msq_pkg::MD_NREQ, 200, n);
        check(mode === msq_pkg::MD_NREQ && rstPinOeN === 1'b1, "release");
        $display("reset test done");
        for (int k = 0; k < 3; k++) begin
            sw = (k == 0) ? 2'h3 : 2'(rnd());
            cmd({msq_pkg::OP_SWITCH, 3'h0, sw});
            cycles(600);
            check({highSideSwitch, lowSideSwitch} === sw, "switch outputs");
        end
        cmd(opByte(msq_pkg::OP_READ, 5'h0));
        check(rx[msq_pkg::ST_HS] === sw[1] && rx[msq_pkg::ST_LS] === sw[0], "status");
        msq_host_model_i.xfer(opByte(msq_pkg::OP_WDTRIG, 5'h0), 7, rx);
        cycles(600);
        check(mode === msq_pkg::MD_NREQ, "short frame ignored");
        $display("switch test done");
        goStop();
        msq_host_model_i.csWake();
        wait_mode(msq_pkg::MD_NREQ, 8000, n);
        check(n >= 890 && n < 8000 && vddOn === 1'b1 && rstPinOeN === 1'b1, "cs wake");
        cycles(9000);
        // The wake flag keeps the interrupt low, so it must be read before the bus test
        check(irqN === 1'b0, "chip select wake interrupt");
        cmd(opByte(msq_pkg::OP_READ, 5'h0));
        check(rx[msq_pkg::ST_WCS] === 1'b1 && irqN === 1'b1, "cs wake flag read");
        $display("chip select wake test done");
        goStop();
        linDominant = 1'b1;
        cycles(100);
        linDominant = 1'b0;
        cycles(2000);
        check(mode === msq_pkg::MD_STOP && irqN === 1'b1, "bus glitch ignored");
        linDominant = 1'b1;
        n = 0;
        while (irqN !== 1'b0 && n < 4000) begin
            cycles(1);
            n++;
        end
        check(n >= 1100 && n <= 1910, "bus wake interrupt");
        linDominant = 1'b0;
        wait_mode(msq_pkg::MD_NREQ, 3000, n);
        check(irqN === 1'b0, "interrupt held until read");
        cmd(opByte(msq_pkg::OP_READ, 5'h0));
        check(rx[msq_pkg::ST_WBUS] === 1'b1 && irqN === 1'b1, "read releases");
        $display("bus wake test done");
        goStop();
        wakeIn = 4'(rnd()) | 4'h1;
        cycles(500);
        wakeIn = 4'h0;
        cycles(3000);
        check(mode === msq_pkg::MD_STOP, "short wake pulse ignored");
        wakeIn = 4'(rnd()) | 4'h1;
        wait_mode(msq_pkg::MD_NREQ, 5000, n);
        check(n >= 800 && n <= 3810, "wake input filter");
        $display("wake input test done");
        txdIn = 1'b0;
        cycles(100);
        check(linDriveDom === 1'b1, "driver follows transmit input");
        cycles(500);
        check(linDriveDom === 1'b0, "permanent dominant cut off");
        txdIn = 1'b1;
        cmd(opByte(msq_pkg::OP_READ, 5'h0));
        check(rx[msq_pkg::ST_TXDOM] === 1'b1, "dominant flag");
        wait_mode(msq_pkg::MD_RESET, NRT + 20, n);
        check(mode === msq_pkg::MD_RESET && rstPinOeN === 1'b0, "timeout reset");
        wait_mode(msq_pkg::MD_NREQ, 200, n);
        check(mode === msq_pkg::MD_NREQ, "restart normal request");
        $display("timeout test done");
        cmd(opByte(msq_pkg::OP_WDTRIG, 5'h0));
        cmd(opByte(msq_pkg::OP_SLEEP, 5'h0));
        check(mode === msq_pkg::MD_SLEEP && vddOn === 1'b0, "sleep entry");
        linDominant = 1'b1;
        wait_mode(msq_pkg::MD_RESET, 400, n);
        linDominant = 1'b0;
        check(mode === msq_pkg::MD_RESET && vddOn === 1'b1 && n >= 200, "sleep bus wake");
        $display("sleep test done");
        report_and_stop();
    end
endmodule
`default_nettype wire

// ### msq_pkg.sv
/*
 * Constants, mode codes and carrier types of the operating-mode sequencer.
 * Assumes a 100 MHz system clock; every cycle count except CYC_RST_GUARD is derived from it.
 */
package msq_pkg;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned FRAME_BITS = 8;

    // Times in their own units, typical figures where a range is given
    localparam int unsigned T_WUF_US = 20;
    localparam int unsigned T_WUCS_US = 15;
    localparam int unsigned T_WAKE_STOP_US = 13;
    localparam int unsigned T_PROPWL_US = 70;
    localparam int unsigned T_NRTOUT_MS = 150;
    localparam int unsigned T_RST_MS = 1;
    localparam int unsigned T_TXDDOM_S = 1;

    localparam int unsigned CYC_WUF = T_WUF_US * CLK_MHZ;
    localparam int unsigned CYC_WUCS = T_WUCS_US * CLK_MHZ;
    localparam int unsigned CYC_WAKE_STOP = T_WAKE_STOP_US * CLK_MHZ;
    localparam int unsigned CYC_PROPWL = T_PROPWL_US * CLK_MHZ;
    localparam int unsigned CYC_NRTOUT = T_NRTOUT_MS * 1000 * CLK_MHZ;
    localparam int unsigned CYC_RST = T_RST_MS * 1000 * CLK_MHZ;
    localparam int unsigned CYC_TXDDOM = T_TXDDOM_S * 1000000 * CLK_MHZ;
    // Guard after releasing the reset pin before its level is trusted again
    localparam int unsigned CYC_RST_GUARD = 4;

    // Command byte: opcode in the top three bits
    localparam int unsigned OP_MSB = 7;
    localparam int unsigned OP_LSB = 5;
    localparam logic [2:0] OP_READ = 3'h0;
    localparam logic [2:0] OP_WDTRIG = 3'h1;
    localparam logic [2:0] OP_STOP = 3'h2;
    localparam logic [2:0] OP_SLEEP = 3'h3;
    localparam logic [2:0] OP_SWITCH = 3'h4;
    localparam int unsigned SW_PWM_BIT = 2;
    localparam int unsigned SW_HS_BIT = 1;
    localparam int unsigned SW_LS_BIT = 0;

    // Status byte shifted out on every frame
    localparam int unsigned ST_TXDOM = 7;
    localparam int unsigned ST_WBUS = 6;
    localparam int unsigned ST_WLX = 5;
    localparam int unsigned ST_WCS = 4;
    localparam int unsigned ST_HS = 3;
    localparam int unsigned ST_LS = 2;
    localparam int unsigned ST_PWM = 1;

    typedef enum logic [4:0] {
        MD_RESET = 5'h01,
        MD_NREQ = 5'h02,
        MD_NORM = 5'h04,
        MD_STOP = 5'h08,
        MD_SLEEP = 5'h10
    } msq_mode_t;

    typedef struct packed {
        logic [3:0] cnt;
        logic [7:0] data;
    } msq_frame_t;
endpackage

// ### msq_spi_link.sv
/*
 * Serial shift logic clocked by the host's serial clock.
 * Assumes the serial clock stands still while chip select is high and that
 * the status snapshot does not change while chip select is low.
 */
`timescale 1ns/1ps
`default_nettype none
module msq_spi_link (
    // Link clock and reset
    input wire logic sclk,
    input wire logic rst,
    // Serial pins
    input wire logic csN,
    input wire logic mosi,
    output logic miso,
    output logic misoOeN,
    // System side
    input wire logic [7:0] snap,
    output msq_pkg::msq_frame_t frame
);
    logic firstQ;
    logic outQ;
    logic outD;
    msq_pkg::msq_frame_t q;
    msq_pkg::msq_frame_t d;

    // Chip select high re-arms the frame start, as no clock edge exists then
    always_ff @(posedge sclk or posedge rst or posedge csN) begin
        if (rst || csN) begin
            firstQ <= 1'b1;
        end else begin
            firstQ <= 1'b0;
        end
    end

    always_comb begin
        d = q;
        outD = 1'b0;
        if (firstQ) begin
            d.cnt = 4'h1;
            d.data = {7'h00, mosi};
            outD = snap[6];
        end else begin
            // Count saturates so an over-long frame never aliases to eight
            if (q.cnt != 4'hf) begin
                d.cnt = q.cnt + 4'h1;
            end
            d.data = {q.data[6:0], mosi};
            if (q.cnt < 4'h7) begin
                outD = snap[3'(4'h6 - q.cnt)];
            end
        end
    end

    // Shifted data is kept after the frame so the system side can latch it
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            q <= '0;
            outQ <= 1'b0;
        end else begin
            q <= d;
            outQ <= outD;
        end
    end

    assign frame = q;
    assign miso = firstQ ? snap[7] : outQ;
    assign misoOeN = csN;
endmodule
`default_nettype wire
